/* hdl/plcc_pkg.sv */
// Package holding offsets, field positions and types of the link cap/control register block
package plcc_pkg;
    // Register offsets (byte addresses)
    localparam logic [11:0] LINK_CAP_OFS = 12'h004_C;
    localparam logic [11:0] LINK_CTL_OFS = 12'h005_0;
    // Field positions
    localparam int BW_NOTIFY_BIT = 21;
    localparam int PORT_IDX_LSB = 24;
    localparam int ASPM_LSB = 0;
    localparam int RCB_BIT = 3;
    localparam int LINK_OFF_BIT = 4;
    // Values after reset
    localparam logic [1:0] ASPM_RST = 2'h0;
    localparam logic LINK_OFF_RST = 1'b0;
    // Low-power entry selections
    localparam logic [1:0] ASPM_NONE = 2'h0;
    localparam logic [1:0] ASPM_L0S = 2'h1;
    localparam logic [1:0] ASPM_L1 = 2'h2;
    localparam logic [1:0] ASPM_BOTH = 2'h3;

    // Register access request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } plcc_req_t;

    // All state of the register block
    typedef struct packed {
        logic [1:0] aspm;
        logic link_off;
        logic [31:0] rdata;
    } plcc_state_t;
endpackage : plcc_pkg

/* hdl/plcc_regs.sv */
// Link capability upper fields and link control low fields of one switch port
//
// Contract
// - Downstream ports report bandwidth notification capable
// - Capability top byte returns port index
// - ASPM field selects L0s/L1 entry
// - ASPM resets to zero unless preloaded
// - L0s enable gates transmitter only
// - Read completion boundary reads zero
// - Downstream link_off bit disables link
// - Upstream ignores link_off bit
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module plcc_regs
#(
    parameter int PORT_INDEX = 0,
    parameter bit IS_DOWNSTREAM = 1'b1
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Register port
    input wire plcc_pkg::plcc_req_t req_i,
    output logic [31:0] rdata_o,
    // Preload from serial configuration memory
    input wire logic preload_vld_i,
    input wire logic [1:0] preload_aspm_i,
    // Controls to link training
    output logic tx_l0s_en_o,
    output logic l1_en_o,
    output logic rx_l0s_accept_o,
    output logic link_off_o
);
    import plcc_pkg::*;

    // Refuse an index outside the sixteen ports of the switch
    if (PORT_INDEX < 0 || PORT_INDEX > 15)
    begin : g_bad_index
        $error("PORT_INDEX out of range");
    end

    // Address decode for the capability word, shared by datapath and checks
    function automatic logic is_cap(input logic [11:0] addr);
        // Exact match only; neighbouring offsets are unmapped
        return addr == LINK_CAP_OFS;
    endfunction : is_cap

    // Address decode for the control word
    function automatic logic is_ctl(input logic [11:0] addr);
        // Exact match only; byte lanes are not decoded separately
        return addr == LINK_CTL_OFS;
    endfunction : is_ctl

    // Constant capability image
    localparam logic [7:0] PORT_IDX = 8'(PORT_INDEX);

    // Registered state and its next value
    plcc_state_t s_q;
    plcc_state_t s_d;
    // Readback images of the two words
    logic [31:0] cap_val;
    logic [15:0] ctl_val;

    // Capability readback, upper fields only
    always_comb
    begin
        // Fields below bit 21 live outside this block and read zero here
        cap_val = 32'h0000_0000;
        cap_val[BW_NOTIFY_BIT] = IS_DOWNSTREAM;
        cap_val[PORT_IDX_LSB +: 8] = PORT_IDX;
    end

    // Control readback
    always_comb
    begin
        // Reserved and foreign bits start at zero
        ctl_val = 16'h0000;
        ctl_val[ASPM_LSB +: 2] = s_q.aspm;
        ctl_val[RCB_BIT] = 1'b0;
        ctl_val[LINK_OFF_BIT] = s_q.link_off;
    end

    // Next state: writes, preload and read data
    always_comb
    begin
        s_d = s_q;
        // Preload overrides the reset value
        // preload replaces default
        if (preload_vld_i)
        begin
            s_d.aspm = preload_aspm_i;
        end
        // Checked after the preload so a software write in the same cycle wins
        // only writable fields stored
        if (req_i.wr && is_ctl(req_i.addr))
        begin
            s_d.aspm = req_i.wdata[ASPM_LSB +: 2];
            s_d.link_off = req_i.wdata[LINK_OFF_BIT];
        end
        // Read data for the cycle after the strobe
        if (req_i.rd)
        begin
            if (is_cap(req_i.addr))
                s_d.rdata = cap_val;
            else if (is_ctl(req_i.addr))
                s_d.rdata = {16'h0000, ctl_val};
            // Unmapped offsets answer zero
            else
                s_d.rdata = 32'h0000_0000;
        end
        else
        begin
            // No read this cycle: the data port rests at zero
            s_d.rdata = 32'h0000_0000;
        end
    end

    // State register
    // Reset is asynchronous so the link never sees a stale disable request
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_q.aspm <= ASPM_RST;
            s_q.link_off <= LINK_OFF_RST;
            s_q.rdata <= 32'h0000_0000;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign rdata_o = s_q.rdata;
    assign tx_l0s_en_o = s_q.aspm[0];
    // Receiver takes L0s from the partner whatever the field holds
    assign rx_l0s_accept_o = 1'b1;
    assign l1_en_o = s_q.aspm[1];
    assign link_off_o = IS_DOWNSTREAM ? s_q.link_off : 1'b0;

    // Assertions: all sample on the one clock and sleep while reset is low
    // index in top byte
    a_cap_read: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.rd && is_cap(req_i.addr) |=> rdata_o[31:24] == PORT_IDX)
        else $error("port index wrong");
    a_notify_bit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.rd && is_cap(req_i.addr) |=> rdata_o[21] == IS_DOWNSTREAM)
        else $error("notify bit wrong");
    a_cap_reserved: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.rd && is_cap(req_i.addr) |=> rdata_o[23:22] == 2'h0)
        else $error("reserved cap bits set");
    a_ctl_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.rd && is_ctl(req_i.addr) |=> rdata_o[3:2] == 2'h0)
        else $error("boundary or reserved bit set");
    a_ctl_upper: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.rd && is_ctl(req_i.addr) |=> rdata_o[31:5] == 27'h000_0000)
        else $error("unused control bits set");
    a_aspm_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.wr && is_ctl(req_i.addr)
        |=> {l1_en_o, tx_l0s_en_o} == $past(req_i.wdata[1:0]))
        else $error("aspm not stored");
    a_aspm_readback: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.rd && is_ctl(req_i.addr) && !preload_vld_i
        |=> rdata_o[1:0] == {l1_en_o, tx_l0s_en_o})
        else $error("aspm readback differs");
    a_aspm_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !preload_vld_i && !(req_i.wr && is_ctl(req_i.addr))
        |=> $stable({l1_en_o, tx_l0s_en_o}))
        else $error("aspm changed unasked");
    a_preload_aspm: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        preload_vld_i && !(req_i.wr && is_ctl(req_i.addr))
        |=> {l1_en_o, tx_l0s_en_o} == $past(preload_aspm_i))
        else $error("preload ignored");
    a_rx_l0s: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        rx_l0s_accept_o)
        else $error("receiver l0s blocked");
    a_link_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.wr && is_ctl(req_i.addr)
        |=> link_off_o == (IS_DOWNSTREAM && $past(req_i.wdata[LINK_OFF_BIT])))
        else $error("link_off wrong");
    a_link_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !(req_i.wr && is_ctl(req_i.addr)) |=> $stable(link_off_o))
        else $error("link_off changed unasked");
    a_upstream_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !IS_DOWNSTREAM |-> !link_off_o)
        else $error("upstream link disabled");
    a_cap_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.wr && is_cap(req_i.addr) && !preload_vld_i
        |=> $stable({l1_en_o, tx_l0s_en_o, link_off_o}))
        else $error("cap write changed state");

    // Covers for the main scenarios
    c_both: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        tx_l0s_en_o && l1_en_o);
    c_off: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        link_off_o ##1 !link_off_o);
    c_cap_rd: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.rd && is_cap(req_i.addr));
    c_ctl_rd: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        req_i.rd && is_ctl(req_i.addr));
    c_preload_clash: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        preload_vld_i && req_i.wr && is_ctl(req_i.addr));
endmodule : plcc_regs

/* dv/plcc_regs_bench.sv */
// Self-checking bench for the link capability and control registers
`timescale 1ns/100ps
module plcc_regs_bench;
    import plcc_pkg::*;
    // Clock, reset and stimulus shared by both ports
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    plcc_req_t req = '0;
    logic pre_vld = 1'b0;
    logic [1:0] pre_aspm = 2'h0;
    // Outputs: {link_off, rx_accept, l1, tx_l0s} per port
    logic [31:0] rd_dn, rd_up;
    logic [3:0] o_dn, o_up;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    // Downstream port 5 and upstream port 10
    plcc_regs #(.PORT_INDEX(5), .IS_DOWNSTREAM(1'b1)) DUT (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .req_i(req), .rdata_o(rd_dn), .preload_vld_i(pre_vld),
        .preload_aspm_i(pre_aspm), .tx_l0s_en_o(o_dn[0]), .l1_en_o(o_dn[1]),
        .rx_l0s_accept_o(o_dn[2]), .link_off_o(o_dn[3]));
    plcc_regs #(.PORT_INDEX(10), .IS_DOWNSTREAM(1'b0)) DUT_UP (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .req_i(req), .rdata_o(rd_up), .preload_vld_i(pre_vld),
        .preload_aspm_i(pre_aspm), .tx_l0s_en_o(o_up[0]), .l1_en_o(o_up[1]),
        .rx_l0s_accept_o(o_up[2]), .link_off_o(o_up[3]));
    // Free-running clock
    initial
    begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // Verdict and end of run
    task automatic conclude();
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One write (w=1) or read (w=0); results settled on return
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge sys_clk_i);
        req <= '0;
        #1;
    endtask : acc
    // Compare the four control outputs of one port
    task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_out
    // Values after reset
    task automatic t_reset();
        acc(1'b0, LINK_CTL_OFS, 32'h0);
        chk(rd_dn, 32'h0000_0000);
        chk_out(o_dn, 4'h4);
        chk_out(o_up, 4'h4);
    endtask : t_reset
    // Capability word, write ignored
    task automatic t_cap();
        acc(1'b1, LINK_CAP_OFS, 32'hFFFF_FFFF);
        chk_out(o_dn, 4'h4);
        acc(1'b0, LINK_CAP_OFS, 32'h0);
        chk(rd_dn, 32'h0520_0000);
        chk(rd_up, 32'h0A00_0000);
    endtask : t_cap
    // Every low-power entry code, on both ports
    task automatic t_aspm();
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b1, LINK_CTL_OFS, 32'(i));
            acc(1'b0, LINK_CTL_OFS, 32'h0);
            chk(rd_dn, 32'(i));
            chk(rd_up, 32'(i));
            chk_out(o_dn, {2'b01, 2'(i)});
            chk_out(o_up, {2'b01, 2'(i)});
        end
    endtask : t_aspm
    // All-ones write, link disable, unmapped read
    task automatic t_ctl();
        acc(1'b1, LINK_CTL_OFS, 32'hFFFF_FFFF);
        chk_out(o_dn, 4'hF);
        chk_out(o_up, 4'h7);
        acc(1'b0, LINK_CTL_OFS, 32'h0);
        chk(rd_dn, 32'h0000_0013);
        acc(1'b1, LINK_CTL_OFS, 32'h0);
        chk_out(o_dn, 4'h4);
        chk_out(o_up, 4'h4);
        acc(1'b0, 12'h0F0, 32'h0);
        chk(rd_dn, 32'h0000_0000);
    endtask : t_ctl
    // Preload alone, then against a write in the same cycle
    task automatic t_preload();
        @(posedge sys_clk_i);
        pre_vld <= 1'b1;
        pre_aspm <= 2'h2;
        @(posedge sys_clk_i);
        pre_aspm <= 2'h3;
        req <= '{addr: LINK_CTL_OFS, wdata: 32'h1, wr: 1'b1, rd: 1'b0};
        #1;
        chk_out(o_dn, 4'h6);
        chk_out(o_up, 4'h6);
        @(posedge sys_clk_i);
        pre_vld <= 1'b0;
        req <= '0;
        #1;
        chk_out(o_dn, 4'h5);
        chk_out(o_up, 4'h5);
    endtask : t_preload
    // Reset in mid-run clears what software wrote
    task automatic t_mid_reset();
        acc(1'b1, LINK_CTL_OFS, 32'h0000_0013);
        chk_out(o_dn, 4'hF);
        chk_out(o_up, 4'h7);
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        #1;
        chk_out(o_dn, 4'h4);
        chk_out(o_up, 4'h4);
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        acc(1'b0, LINK_CTL_OFS, 32'h0);
        chk(rd_dn, 32'h0000_0000);
        chk_out(o_dn, 4'h4);
    endtask : t_mid_reset
    // Hang guard
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            conclude();
        end
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_cap();
        t_aspm();
        t_ctl();
        t_preload();
        t_mid_reset();
        conclude();
    end
endmodule : plcc_regs_bench
